/* File: perr_regs.v */
// Functional notes
// - a detected end-to-end parity error sets the parity status flag, which software clears by writing one.
// - each rise of the parity status flag is reported with the severity held in a two-bit field.
// - parity severity 0 sends nothing, 1 a correctable, 2 a non-fatal and 3 a fatal message to the root.
// - the eight-bit parity tally rises by one for each detected parity error.
// - the parity tally stops at all ones and never wraps to zero.
// - reading the parity tally returns its value and then clears it.
// - a posted-queue packet dropped for age sets status bit 0, cleared by writing one.
// - a non-posted-queue packet dropped for age sets status bit 1, cleared by writing one.
// - a completion-queue packet dropped for age sets status bit 2, cleared by writing one.
// - an inserted-queue packet dropped for age sets status bit 3, cleared by writing one.
// - posted and non-posted drops report per severity fields at bits 1:0 and 3:2 on a status rise.
// - completion and inserted drops report per severity fields at bits 5:4 and 7:6 on a status rise.
// - each drop severity field selects none, correctable, non-fatal or fatal toward the root.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "perr_defs.vh"
module perr_regs #(
	parameter ADDR_W = 12
) (
	input  wire              clk,
	input  wire              nrst,
	input  wire              hot_rst,
	input  wire              e2e_parity_err,
	input  wire              posted_age_drop,
	input  wire              nonposted_age_drop,
	input  wire              completion_age_drop,
	input  wire              inserted_age_drop,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	output reg               err_msg_valid,
	output reg  [1:0]        err_msg_sev,
	input  wire              err_msg_ready
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	reg                      parity_status;
	reg  [1:0]               parity_sev;
	reg  [`PERR_NUM_Q-1:0]   to_status;
	reg  [7:0]               to_sev;
	wire [`PERR_CNT_W-1:0]   parity_err_tally;
	reg  [ADDR_W-1:0]        aw_addr;
	reg  [31:0]              w_data;
	reg  [3:0]               w_strb;
	reg                      aw_have;
	reg                      w_have;
	wire                     arb_valid;
	wire [1:0]               arb_sev;
	wire [`PERR_NUM_Q:0]     arb_src;
	wire [`PERR_NUM_Q-1:0]   drops;
	wire                     wr_go;
	wire                     rd_go;
	wire                     wr_lane0;
	wire                     tally_clr;
	reg  [31:0]              next_rdata;
	reg                      next_rok;
	reg                      wr_ok;

	assign drops    = {inserted_age_drop, completion_age_drop, nonposted_age_drop, posted_age_drop};
	assign wr_go    = aw_have & w_have & ~s_axi_bvalid;
	assign rd_go    = s_axi_arvalid & s_axi_arready;
	assign wr_lane0 = wr_go & w_strb[0];
	assign tally_clr = rd_go & (s_axi_araddr == `PERR_OFS_PE_COUNT);

	// ----------------------------------------
	// write channels: address and data taken in either order
	// ----------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= {ADDR_W{1'b0}};
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready  <= ~w_have & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have <= 1'b0;
				w_have  <= 1'b0;
			end
		end
	end

	// decode of the write address
	always @* begin
		case (aw_addr)
			`PERR_OFS_PE_STATUS,
			`PERR_OFS_PE_RPT_CTL,
			`PERR_OFS_PE_COUNT,
			`PERR_OFS_TO_STATUS,
			`PERR_OFS_TO_RPT_CTL: wr_ok = 1'b1;
			default:              wr_ok = 1'b0;
		endcase
	end

	// write response
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PERR_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? `PERR_RESP_OKAY : `PERR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always @* begin
		next_rdata = 32'h00000000;
		next_rok   = 1'b1;
		case (s_axi_araddr)
			`PERR_OFS_PE_STATUS:  next_rdata[0]   = parity_status;
			`PERR_OFS_PE_RPT_CTL: next_rdata[1:0] = parity_sev;
			`PERR_OFS_PE_COUNT:   next_rdata[7:0] = parity_err_tally;
			`PERR_OFS_TO_STATUS:  next_rdata[3:0] = to_status;
			`PERR_OFS_TO_RPT_CTL: next_rdata[7:0] = to_sev;
			default:              next_rok        = 1'b0;
		endcase
	end

	// one read at a time, answer one cycle after the address is taken
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PERR_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rok ? `PERR_RESP_OKAY : `PERR_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// non-sticky status, cleared by any reset
	// ----------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			parity_status <= 1'b0;
			to_status     <= {`PERR_NUM_Q{1'b0}};
		end else if (hot_rst) begin
			parity_status <= 1'b0;
			to_status     <= {`PERR_NUM_Q{1'b0}};
		end else begin
			// set wins over a write-one clear in the same cycle
			if (e2e_parity_err) begin
				parity_status <= 1'b1;
			end else if (wr_lane0 && aw_addr == `PERR_OFS_PE_STATUS && w_data[0]) begin
				parity_status <= 1'b0;
			end
			if (wr_lane0 && aw_addr == `PERR_OFS_TO_STATUS) begin
				to_status <= (to_status & ~w_data[3:0]) | drops;
			end else begin
				to_status <= to_status | drops;
			end
		end
	end

	// parity severity: plain control, reloaded with its reset value 2 by any reset
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			parity_sev <= `PERR_RST_PE_RPT_CTL;
		end else if (hot_rst) begin
			parity_sev <= `PERR_RST_PE_RPT_CTL;
		end else if (wr_lane0 && aw_addr == `PERR_OFS_PE_RPT_CTL) begin
			parity_sev <= w_data[1:0];
		end
	end

	// drop severity fields: sticky, only the fundamental reset reloads them with their reset value
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			to_sev <= `PERR_RST_TO_RPT_CTL;
		end else if (wr_lane0 && aw_addr == `PERR_OFS_TO_RPT_CTL) begin
			to_sev <= w_data[7:0];
		end
	end

	// ----------------------------------------
	// parity tally: sticky, so fed only by the fundamental reset
	// ----------------------------------------
	perr_sat_counter #(
		.WIDTH (`PERR_CNT_W)
	) u_tally (
		.clk   (clk),
		.nrst  (nrst),
		.inc   (e2e_parity_err & ~hot_rst),
		.clr   (tally_clr),
		.count (parity_err_tally)
	);

	// ----------------------------------------
	// message generation on zero-to-one rises
	// ----------------------------------------
	perr_msg_arbiter #(
		.N (`PERR_NUM_Q + 1)
	) u_arb (
		.clk       (clk),
		.nrst      (nrst),
		.req       ({drops & ~to_status, e2e_parity_err & ~parity_status} & {(`PERR_NUM_Q+1){~hot_rst}}),
		.sev       ({to_sev, parity_sev}),
		.msg_ready (~err_msg_valid | err_msg_ready),
		.msg_valid (arb_valid),
		.msg_sev   (arb_sev),
		.msg_src   (arb_src)
	);

	// message outputs: loaded only when empty or taken, so each message moves once and its severity stands
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err_msg_valid <= 1'b0;
			err_msg_sev   <= `PERR_SEV_NONE;
		end else if (!err_msg_valid || err_msg_ready) begin
			err_msg_valid <= arb_valid;
			err_msg_sev   <= arb_sev;
		end
	end
endmodule // perr_regs
`default_nettype wire

/* File: perr_defs.vh */
`ifndef PERR_DEFS_VH
`define PERR_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PERR_OFS_PE_STATUS   12'h744
`define PERR_OFS_PE_RPT_CTL  12'h748
`define PERR_OFS_PE_COUNT    12'h74C
`define PERR_OFS_TO_STATUS   12'h754
`define PERR_OFS_TO_RPT_CTL  12'h758
// ----------------------------------------
// reset values
// ----------------------------------------
`define PERR_RST_PE_RPT_CTL  2'h2
`define PERR_RST_TO_RPT_CTL  8'h82
// ----------------------------------------
// field layout and encodings
// ----------------------------------------
`define PERR_SEV_W           2
`define PERR_CNT_W           8
`define PERR_NUM_Q           4
`define PERR_SEV_NONE        2'h0
`define PERR_SEV_COR         2'h1
`define PERR_SEV_NONFATAL    2'h2
`define PERR_SEV_FATAL       2'h3
`define PERR_RESP_OKAY       2'h0
`define PERR_RESP_SLVERR     2'h2
// ----------------------------------------
// timing: drop age of a queued packet
// ----------------------------------------
`define PERR_AGE_LIMIT_MS    50
`endif

/* File: perr_sat_counter.v */
`timescale 1ns/100ps
`default_nettype none
`include "perr_defs.vh"
// ----------------------------------------
// saturating clear-on-read counter
// ----------------------------------------
module perr_sat_counter #(
	parameter WIDTH = `PERR_CNT_W
) (
	input  wire             clk,
	input  wire             nrst,
	input  wire             inc,
	input  wire             clr,
	output reg  [WIDTH-1:0] count
);
	// an event in the read cycle is counted after the clear, not lost
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= {WIDTH{1'b0}};
		end else if (clr) begin
			count <= inc ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
		end else if (inc && (count != {WIDTH{1'b1}})) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // perr_sat_counter
`default_nettype wire

/* File: perr_msg_arbiter.v */
`timescale 1ns/100ps
`default_nettype none
`include "perr_defs.vh"
// ----------------------------------------
// pending-message arbiter toward the root
// ----------------------------------------
module perr_msg_arbiter #(
	parameter N = 5
) (
	input  wire                     clk,
	input  wire                     nrst,
	input  wire [N-1:0]             req,
	input  wire [N*`PERR_SEV_W-1:0] sev,
	input  wire                     msg_ready,
	output reg                      msg_valid,
	output reg  [`PERR_SEV_W-1:0]   msg_sev,
	output reg  [N-1:0]             msg_src
);
	reg  [N-1:0]           pend;
	reg  [N*`PERR_SEV_W-1:0] pend_sev;
	reg  [N-1:0]           pick;
	reg                    found;
	integer                i;
	integer                j;
	wire                   taken = msg_valid & msg_ready;
	// lowest pending source wins
	always @* begin
		pick  = {N{1'b0}};
		found = 1'b0;
		for (i = 0; i < N; i = i + 1) begin
			if (pend[i] && !found) begin
				pick[i] = 1'b1;
				found   = 1'b1;
			end
		end
	end
	// one pending slot per source, so one message per rising edge
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_pend
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					pend[g]                                 <= 1'b0;
					pend_sev[g*`PERR_SEV_W +: `PERR_SEV_W] <= `PERR_SEV_NONE;
				end else if (req[g] && (sev[g*`PERR_SEV_W +: `PERR_SEV_W] != `PERR_SEV_NONE)) begin
					pend[g]                                 <= 1'b1;
					pend_sev[g*`PERR_SEV_W +: `PERR_SEV_W] <= sev[g*`PERR_SEV_W +: `PERR_SEV_W];
				end else if (!msg_valid && pick[g]) begin
					pend[g] <= 1'b0;
				end
			end
		end
	endgenerate
	// message register held until taken
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			msg_valid <= 1'b0;
			msg_sev   <= `PERR_SEV_NONE;
			msg_src   <= {N{1'b0}};
		end else if (!msg_valid || taken) begin
			msg_valid <= 1'b0;
			if (!msg_valid && found) begin
				msg_valid <= 1'b1;
				msg_src   <= pick;
				for (j = 0; j < N; j = j + 1) begin
					if (pick[j]) begin
						msg_sev <= pend_sev[j*`PERR_SEV_W +: `PERR_SEV_W];
					end
				end
			end
		end
	end
endmodule // perr_msg_arbiter
`default_nettype wire

/* File: perr_regs_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bus and message checks
// ----------------------------------------
module perr_regs_asserts (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        err_msg_valid,
	input wire logic        err_msg_ready,
	input wire logic [1:0]  err_msg_sev
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// a read address taken by the slave
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// answers stand until taken
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("address taken while answer pending");
	property p_r_answer; s_ar_taken |=> s_axi_rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_b_resp; s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
	a_b_resp: assert property (p_b_resp) else $error("bad write response");
	property p_r_resp; s_axi_rvalid |-> s_axi_rresp == 2'h0 || (s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0); endproperty
	a_r_resp: assert property (p_r_resp) else $error("bad read response");
	// a message stands with its severity until the root takes it
	property p_msg_hold; err_msg_valid && !err_msg_ready |=> err_msg_valid && $stable(err_msg_sev); endproperty
	a_msg_hold: assert property (p_msg_hold) else $error("message withdrawn");
	property p_msg_sev; err_msg_valid |-> err_msg_sev != 2'h0; endproperty
	a_msg_sev: assert property (p_msg_sev) else $error("message without severity");
endmodule // perr_regs_asserts
`default_nettype wire

/* File: perr_root_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// root side taking error messages
// ----------------------------------------
module perr_root_model (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       hold,
	input  wire logic       err_msg_valid,
	input  wire logic [1:0] err_msg_sev,
	output var  logic       err_msg_ready
);
	logic [1:0] got[$];
	// ready moves only after an edge; hold stalls the root
	always @(posedge clk or negedge nrst) begin
		if (!nrst) err_msg_ready <= 1'h0;
		else err_msg_ready <= !hold;
	end
	// log every message taken
	always @(posedge clk) begin
		if (nrst && err_msg_valid && err_msg_ready) got.push_back(err_msg_sev);
	end
endmodule // perr_root_model
`default_nettype wire

/* File: perr_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module perr_regs_tb;
	logic        clk, nrst, hot_rst, hold, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, msg_valid, msg_ready;
	logic [4:0]  ev, sts;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [1:0]  bresp, rresp, msg_sev, ga, gb;
	logic [1:0]  exp_q[$];
	int          num_errors, checked, seed, tally, pctl, dctl, v, s, r, n;
	perr_regs dut (.clk(clk), .nrst(nrst), .hot_rst(hot_rst), .e2e_parity_err(ev[0]), .posted_age_drop(ev[1]),
		.nonposted_age_drop(ev[2]), .completion_age_drop(ev[3]), .inserted_age_drop(ev[4]),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .err_msg_valid(msg_valid), .err_msg_sev(msg_sev), .err_msg_ready(msg_ready));
	perr_root_model root (.clk(clk), .nrst(nrst), .hold(hold), .err_msg_valid(msg_valid), .err_msg_sev(msg_sev),
		.err_msg_ready(msg_ready));
	// clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task automatic complete_run();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// severity field of a source: 0 parity, 1..4 queues
	function automatic int sv(input int k);
		return (k == 0) ? pctl : (dctl >> (2 * (k - 1))) & 3;
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			k++;
		end while (!bvalid && k < 50);
		`CHK(bresp, er)
		if (k >= 50) begin num_errors++; complete_run(); end
	endtask
	task automatic rd(input logic [11:0] a, input logic [1:0] er);
		int k;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
			k++;
		end while (!rvalid && k < 50);
		rd_v = rdata;
		`CHK(rresp, er)
		if (k >= 50) begin num_errors++; complete_run(); end
	endtask
	// event pulses with the model's bookkeeping
	task automatic fire(input int k, input int cnt);
		repeat (cnt) begin
			ev <= 5'h01 << k;
			if (k == 0 && tally < 255) tally++;
			if (!sts[k] && sv(k) != 0) exp_q.push_back(2'(sv(k)));
			sts[k] = 1'h1;
			@(posedge clk);
			ev <= 5'h00;
			@(posedge clk);
		end
	endtask
	// wait for the expected messages, then compare them in order
	task automatic msgs();
		int k;
		for (k = 0; k < 40 && root.got.size() < exp_q.size(); k++) @(posedge clk);
		repeat (4) @(posedge clk);
		`CHK(root.got.size(), exp_q.size())
		while (exp_q.size() > 0 && root.got.size() > 0) begin
			ga = root.got.pop_front();
			gb = exp_q.pop_front();
			`CHK(ga, gb)
		end
		exp_q.delete();
		root.got.delete();
	endtask
	// read every register against the model
	task automatic chk_all();
		rd(12'h744, 2'h0); `CHK(rd_v, {31'h0, sts[0]})
		rd(12'h748, 2'h0); `CHK(rd_v, 32'(pctl))
		rd(12'h74C, 2'h0); `CHK(rd_v, 32'(tally))
		tally = 0;
		rd(12'h754, 2'h0); `CHK(rd_v, {28'h0, sts[4:1]})
		rd(12'h758, 2'h0); `CHK(rd_v, 32'(dctl))
	endtask
	// main sequence
	initial begin
		{nrst, hot_rst, hold, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
		{ev, sts, awaddr, araddr, wdata} = 'h0;
		num_errors = 0; checked = 0; seed = 21; tally = 0; pctl = 2; dctl = 32'h82;
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		repeat (2) @(posedge clk);
		chk_all();
		wr(12'h700, 32'hFFFFFFFF, 2'h2);
		rd(12'h700, 2'h2); `CHK(rd_v, 32'h0)
		wr(12'h748, 32'hFFFFFFFF, 2'h0);
		pctl = 3;
		for (v = 0; v < 4; v++) begin
			for (s = 0; s < 5; s++) begin
				r = $random(seed);
				if (s == 0) pctl = v;
				else dctl = (r & 8'hFF & ~(3 << 2 * (s - 1))) | (v << 2 * (s - 1));
				wr(s == 0 ? 12'h748 : 12'h758, s == 0 ? pctl : dctl, 2'h0);
				hold <= r[8];
				fire(s, 1 + r[9]);
				repeat (8) @(posedge clk);
				hold <= 1'h0;
				msgs();
				chk_all();
				wr(s == 0 ? 12'h744 : 12'h754, 32'h1 << (s == 0 ? 0 : s - 1), 2'h0);
				sts[s] = 1'h0;
				chk_all();
			end
		end
		n = 256 + ({$random(seed)} % 8);
		fire(0, n);
		msgs();
		chk_all();
		chk_all();
		fire(1, 1);
		fire(0, 3);
		msgs();
		hot_rst <= 1'h1;
		@(posedge clk);
		hot_rst <= 1'h0;
		sts = 5'h00;
		pctl = 2;
		chk_all();
		complete_run();
	end
endmodule // perr_regs_tb
bind perr_regs perr_regs_asserts u_chk (.clk(clk), .nrst(nrst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.err_msg_valid(err_msg_valid), .err_msg_ready(err_msg_ready), .err_msg_sev(err_msg_sev));
`default_nettype wire
